// ---- verilog/tgtxf_pkg.sv ----
package tgtxf_pkg;
   localparam int DEPTH = 32;
   localparam int PTR_W = 5;
   localparam int CNT_W = 6;
   localparam int DATA_W = 64;
   localparam int CTRL_W = 9;
   localparam int FAB_W = 67;
   localparam int PMA_W = 64;
   localparam int DATA_KEEP = (FAB_W >= 64) ? 64 : FAB_W;
   localparam int CTRL_KEEP = (FAB_W == 67) ? 3 : ((FAB_W == 66) ? 2 : 9);
   localparam logic [63:0] DATA_MASK = {64{1'b1}} >> (64 - DATA_KEEP);
   localparam logic [8:0] CTRL_MASK = 9'h1ff >> (9 - CTRL_KEEP);
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_THR = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_ISTAT = 8'h0c;
   localparam logic [7:0] OFS_IMASK = 8'h10;
   localparam logic [7:0] OFS_DIV = 8'h14;
   localparam int CTRL_INV_BIT = 2;
   localparam int CTRL_BASER_BIT = 3;
   localparam int THR_FULL_LSB = 0;
   localparam int THR_PFULL_LSB = 8;
   localparam int THR_PEMPTY_LSB = 16;
   localparam int THR_EMPTY_LSB = 24;
   localparam int STAT_FLAG_LSB = 8;
   localparam int IRQ_OVF_BIT = 0;
   localparam int IRQ_UNF_BIT = 1;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [31:0] THR_RST = 32'h0004_171f;
   localparam logic [31:0] DIV_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      MODE_ILK,
      MODE_PHASE,
      MODE_REG
   } tgtxf_mode_type;
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [CTRL_W-1:0] ctrl;
   } tgtxf_word_type;
endpackage

// ---- verilog/tgtxf_top.sv ----
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
// Functional notes
// - Transmit queue stores 32 entries of 73 bits, written by fabric, read by PCS.
// - Full, empty, partial full and partial empty flags compare occupancy to thresholds.
// - Interlaken mode is elastic; writes may outpace the slower read rate.
// - Interlaken mode reads only when the frame generator requests a word.
// - Phase mode reads one word on every read tick, absorbing phase only.
// - Register mode bypasses storage; word and valid pass one output register.
// - Full threshold 0 to 31, default 31; full flag on write side.
// - 66-bit width uses 64 data bits and two low control bits.
// - 67-bit width uses 64 data bits and three low control bits.
// - PCS to PMA width is fixed at build time to 32, 40 or 64.
// - Fabric width is fixed at build time to 32, 40, 50, 64, 66 or 67.
// - Outgoing data can be inverted at run time by a control bit.
// - Empty threshold 0 to 31 default 0; partial full default 23.
// - Empty flag is updated on read ticks and held between them.
// - In 10GBASE-R mode, pulse on each deleted word and each inserted word.
// - Partial full threshold 0 to 31; flag on write side.
module tgtxf_top
   import tgtxf_pkg::*;
(
   input  wire logic                     mclk_in,
   input  wire logic                     rst_in,
   input  wire tgtxf_pkg::tgtxf_word_type fab_word_in,
   input  wire logic                     fab_valid_in,
   input  wire logic                     frame_rd_in,
   output logic [tgtxf_pkg::PMA_W-1:0]   pma_data_out,
   output logic [tgtxf_pkg::CTRL_W-1:0]  pma_ctrl_out,
   output logic                          pma_valid_out,
   output logic                          txq_full_flag_out,
   output logic                          txq_partial_full_flag_out,
   output logic                          txq_empty_flag_out,
   output logic                          txq_partial_empty_flag_out,
   output logic                          txq_word_deleted_pulse_out,
   output logic                          txq_word_inserted_pulse_out,
   output logic                          irq_out,
   input  wire logic [7:0]               s_axi_awaddr_in,
   input  wire logic                     s_axi_awvalid_in,
   output logic                          s_axi_awready_out,
   input  wire logic [31:0]              s_axi_wdata_in,
   input  wire logic [3:0]               s_axi_wstrb_in,
   input  wire logic                     s_axi_wvalid_in,
   output logic                          s_axi_wready_out,
   output logic [1:0]                    s_axi_bresp_out,
   output logic                          s_axi_bvalid_out,
   input  wire logic                     s_axi_bready_in,
   input  wire logic [7:0]               s_axi_araddr_in,
   input  wire logic                     s_axi_arvalid_in,
   output logic                          s_axi_arready_out,
   output logic [31:0]                   s_axi_rdata_out,
   output logic [1:0]                    s_axi_rresp_out,
   output logic                          s_axi_rvalid_out,
   input  wire logic                     s_axi_rready_in
);
   import tgtxf_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   tgtxf_word_type       mem_q [DEPTH];
   logic [PTR_W-1:0]     wptr_q, rptr_q;
   logic [CNT_W-1:0]     cnt_q, cnt_d;
   logic [31:0]          ctrl_q, thr_q, istat_q, imask_q, div_q;
   logic [31:0]          divcnt_q;
   logic [7:0]           aw_addr_q;
   logic [31:0]          w_data_q;
   logic [3:0]           w_strb_q;
   logic                 aw_have_q, w_have_q;
   tgtxf_word_type       last_q;

   wire tgtxf_mode_type  mode = (ctrl_q[1:0] == 2'h0) ? MODE_ILK :
                                (ctrl_q[1:0] == 2'h1) ? MODE_PHASE :
                                MODE_REG;
   wire                  inv = ctrl_q[CTRL_INV_BIT];
   wire                  base_r = ctrl_q[CTRL_BASER_BIT];
   wire [4:0]            thr_full = thr_q[THR_FULL_LSB +: 5];
   wire [4:0]            thr_pfull = thr_q[THR_PFULL_LSB +: 5];
   wire [4:0]            thr_pempty = thr_q[THR_PEMPTY_LSB +: 5];
   wire [4:0]            thr_empty = thr_q[THR_EMPTY_LSB +: 5];

   // Masking narrows the word to the build-time width.
   wire tgtxf_word_type  in_word = '{data: fab_word_in.data & DATA_MASK,
                                     ctrl: fab_word_in.ctrl & CTRL_MASK};
   // A divider written below the running count ticks at once, not on wrap.
   wire                  rd_tick = (divcnt_q >= div_q);
   wire                  rd_want = rd_tick && ((mode == MODE_PHASE) ||
                                   (mode == MODE_ILK && frame_rd_in));
   wire                  stored = (mode != MODE_REG);
   wire                  is_full = (cnt_q == CNT_W'(DEPTH));
   wire                  is_empty = (cnt_q == '0);
   wire                  wr_go = stored && fab_valid_in && !is_full;
   wire                  ovf = stored && fab_valid_in && is_full;
   wire                  rd_go = stored && rd_want && !is_empty;
   wire                  unf = stored && rd_want && is_empty;
   wire tgtxf_word_type  rd_word = unf ? last_q : mem_q[rptr_q];
   wire [63:0]           out_src = (mode == MODE_REG) ? in_word.data :
                                   rd_word.data;
   wire [8:0]            ctrl_src = (mode == MODE_REG) ? in_word.ctrl :
                                    rd_word.ctrl;

   wire                  aw_take = s_axi_awvalid_in && s_axi_awready_out;
   wire                  w_take = s_axi_wvalid_in && s_axi_wready_out;
   wire                  wr_do = aw_have_q && w_have_q;
   wire                  ar_take = s_axi_arvalid_in && s_axi_arready_out;
   wire                  aw_have_d = (aw_have_q || aw_take) && !wr_do;
   wire                  w_have_d = (w_have_q || w_take) && !wr_do;
   wire                  bvalid_d = (s_axi_bvalid_out && !s_axi_bready_in)
                                    || wr_do;
   wire                  rvalid_d = (s_axi_rvalid_out && !s_axi_rready_in)
                                    || ar_take;
   wire                  wa_ctrl = wr_do && (aw_addr_q == OFS_CTRL);
   wire                  wa_thr = wr_do && (aw_addr_q == OFS_THR);
   wire                  wa_istat = wr_do && (aw_addr_q == OFS_ISTAT);
   wire                  wa_imask = wr_do && (aw_addr_q == OFS_IMASK);
   wire                  wa_div = wr_do && (aw_addr_q == OFS_DIV);
   wire                  wa_ok = wa_ctrl || wa_thr || wa_istat ||
                                 wa_imask || wa_div ||
                                 (aw_addr_q == OFS_STAT);
   wire [31:0]           w_clr = merge(32'h0, w_data_q, w_strb_q);
   wire [1:0]            ev = {unf, ovf};
   wire [31:0]           istat_d = (istat_q & ~(wa_istat ? w_clr : 32'h0))
                                   | {30'h0, ev};
   wire [31:0]           stat_v = {20'h0, txq_partial_empty_flag_out,
                                   txq_empty_flag_out,
                                   txq_partial_full_flag_out,
                                   txq_full_flag_out, 2'h0, cnt_q};
   wire                  ra_ok;
   wire [31:0]           ra_data;

   assign ra_ok = (s_axi_araddr_in == OFS_CTRL) ||
                  (s_axi_araddr_in == OFS_THR) ||
                  (s_axi_araddr_in == OFS_STAT) ||
                  (s_axi_araddr_in == OFS_ISTAT) ||
                  (s_axi_araddr_in == OFS_IMASK) ||
                  (s_axi_araddr_in == OFS_DIV);
   assign ra_data = (s_axi_araddr_in == OFS_CTRL) ? ctrl_q :
                    (s_axi_araddr_in == OFS_THR) ? thr_q :
                    (s_axi_araddr_in == OFS_STAT) ? stat_v :
                    (s_axi_araddr_in == OFS_ISTAT) ? istat_q :
                    (s_axi_araddr_in == OFS_IMASK) ? imask_q :
                    (s_axi_araddr_in == OFS_DIV) ? div_q : 32'h0;

   // Occupancy moves by one per write and per read.
   assign cnt_d = cnt_q + CNT_W'(wr_go) - CNT_W'(rd_go);

   // Storage array of 32 words of 73 bits.
   always_ff @(posedge mclk_in) begin
      if (wr_go) begin
         mem_q[wptr_q] <= in_word;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
         divcnt_q <= '0;
         last_q <= '0;
      end else begin
         wptr_q <= wptr_q + PTR_W'(wr_go);
         rptr_q <= stored ? rptr_q + PTR_W'(rd_go) : wptr_q;
         cnt_q <= stored ? cnt_d : '0;
         divcnt_q <= rd_tick ? 32'h0 : divcnt_q + 32'h1;
         if (rd_go) begin
            last_q <= mem_q[rptr_q];
         end
      end
   end

   // Reads follow the frame generator or every tick by mode.
   // Register mode passes the fabric word through one stage.
   // Inversion of outgoing data is a run-time bit.
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pma_data_out <= '0;
         pma_ctrl_out <= '0;
         pma_valid_out <= 1'b0;
      end else begin
         pma_data_out <= out_src ^ {PMA_W{inv}};
         pma_ctrl_out <= ctrl_src;
         pma_valid_out <= (mode == MODE_REG) ? fab_valid_in :
                          (rd_go || (unf && base_r));
      end
   end

   // Threshold flags follow next occupancy.
   // Empty side is refreshed only on read ticks and held between.
   // Deleted and inserted pulses in 10GBASE-R mode.
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         txq_full_flag_out <= 1'b0;
         txq_partial_full_flag_out <= 1'b0;
         txq_empty_flag_out <= 1'b1;
         txq_partial_empty_flag_out <= 1'b1;
         txq_word_deleted_pulse_out <= 1'b0;
         txq_word_inserted_pulse_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         txq_full_flag_out <= cnt_d >= {1'b0, thr_full};
         txq_partial_full_flag_out <= cnt_d >= {1'b0, thr_pfull};
         if (rd_tick) begin
            txq_empty_flag_out <= cnt_d <= {1'b0, thr_empty};
            txq_partial_empty_flag_out <= cnt_d <= {1'b0, thr_pempty};
         end
         txq_word_deleted_pulse_out <= base_r && ovf;
         txq_word_inserted_pulse_out <= base_r && unf;
         irq_out <= |(istat_d & imask_q);
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q <= CTRL_RST;
         thr_q <= THR_RST;
         div_q <= DIV_RST;
         imask_q <= 32'h0;
         istat_q <= 32'h0;
      end else begin
         ctrl_q <= wa_ctrl ? merge(ctrl_q, w_data_q, w_strb_q) & 32'hf
                           : ctrl_q;
         thr_q <= wa_thr ? merge(thr_q, w_data_q, w_strb_q) & 32'h1f1f1f1f
                         : thr_q;
         div_q <= wa_div ? merge(div_q, w_data_q, w_strb_q) : div_q;
         imask_q <= wa_imask ? merge(imask_q, w_data_q, w_strb_q) & 32'h3
                             : imask_q;
         istat_q <= istat_d;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= RESP_OKAY;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         if (aw_take) begin
            aw_addr_q <= s_axi_awaddr_in;
         end
         if (w_take) begin
            w_data_q <= s_axi_wdata_in;
            w_strb_q <= s_axi_wstrb_in;
         end
         s_axi_awready_out <= !aw_have_d && !bvalid_d;
         s_axi_wready_out <= !w_have_d && !bvalid_d;
         s_axi_bvalid_out <= bvalid_d;
         if (wr_do) begin
            s_axi_bresp_out <= wa_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= '0;
         s_axi_rresp_out <= RESP_OKAY;
      end else begin
         s_axi_arready_out <= !rvalid_d;
         s_axi_rvalid_out <= rvalid_d;
         if (ar_take) begin
            s_axi_rdata_out <= ra_data;
            s_axi_rresp_out <= ra_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   chk_occ_bound: assert property (cnt_q <= CNT_W'(DEPTH))
      else $error("occupancy above depth");
   chk_full_thr: assert property (
      ##1 txq_full_flag_out == ($past(cnt_d) >= {1'b0, $past(thr_full)}))
      else $error("full flag mismatch");
   chk_pfull_thr: assert property (
      ##1 txq_partial_full_flag_out ==
          ($past(cnt_d) >= {1'b0, $past(thr_pfull)}))
      else $error("partial full flag mismatch");
   chk_empty_hold: assert property (
      !rd_tick |=> $stable(txq_empty_flag_out))
      else $error("empty flag moved off a read tick");
   chk_ilk_read: assert property (
      (mode == MODE_ILK && !frame_rd_in) |-> !rd_go)
      else $error("interlaken read without request");
   chk_phase_read: assert property (
      (mode == MODE_PHASE && rd_tick && cnt_q != 0 && !wa_ctrl)
      |=> (pma_valid_out && cnt_q <= $past(cnt_q)))
      else $error("phase mode missed a read");
   chk_reg_pass: assert property (
      (mode == MODE_REG && !wa_ctrl) |=>
      (pma_valid_out == $past(fab_valid_in) &&
       pma_ctrl_out == $past(in_word.ctrl)))
      else $error("register mode passthrough wrong");
   chk_del_pulse: assert property (
      (base_r && ovf) |=> txq_word_deleted_pulse_out ##1
      !txq_word_deleted_pulse_out || $past(ovf))
      else $error("delete pulse wrong");
   chk_inv_data: assert property (
      (mode == MODE_REG && inv && !wa_ctrl) |=>
      pma_data_out == ~$past(in_word.data))
      else $error("inversion not applied");
   chk_irq_set: assert property (
      (ovf && imask_q[IRQ_OVF_BIT] && !wa_imask) |=> irq_out)
      else $error("interrupt not raised");
endmodule // tgtxf_top

// ---- dv/tgtxf_fab_model.sv ----
`timescale 1ns/100ps
// Fabric writer: gates each write with valid and may stop on the full flag.
module tgtxf_fab_model
   import tgtxf_pkg::*;
(
   input  wire logic                      mclk_in,
   input  wire logic                      rst_in,
   input  wire logic                      run_in,
   input  wire logic                      stop_on_full_in,
   input  wire logic                      full_in,
   output tgtxf_pkg::tgtxf_word_type      word_out,
   output logic                           valid_out
);
   logic [31:0]    cnt_q;
   tgtxf_word_type cur;

   assign cur = '{data: {~cnt_q, cnt_q}, ctrl: cnt_q[8:0]};
   assign valid_out = run_in & ~(stop_on_full_in & full_in);
   // Between writes the word lines show the inverse, never a stale copy.
   assign word_out = valid_out ? cur : ~cur;

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q <= 32'h0000_0000;
      end else if (valid_out) begin
         cnt_q <= cnt_q + 32'h0000_0001;
      end
   end
endmodule // tgtxf_fab_model

// ---- dv/test_ten_g_pcs_tx_fifo.sv ----
`timescale 1ns/100ps
module test_ten_g_pcs_tx_fifo;
   import tgtxf_pkg::*;
   logic           clk, rst, run, stop, frd, fv, pv, ff, pff, ef, pef;
   logic           dp, ip, irq, inv, ign, gap, regm, fvp;
   tgtxf_word_type fw, e;
   tgtxf_word_type q[$];
   logic [63:0]    pd;
   logic [8:0]     pc;
   logic [7:0]     awaddr, araddr;
   logic [31:0]    wdata, rdata;
   logic [1:0]     bresp, rresp;
   logic           awvalid, awready, wvalid, wready, bvalid, bready;
   logic           arvalid, arready, rvalid, rready;
   int             failures = 0, checks = 0, cyc = 0, last = 0;
   int             dels = 0, ins = 0;

   tgtxf_fab_model fab (.mclk_in(clk), .rst_in(rst), .run_in(run),
      .stop_on_full_in(stop), .full_in(ff), .word_out(fw), .valid_out(fv));

   tgtxf_top dut (.mclk_in(clk), .rst_in(rst), .fab_word_in(fw),
      .fab_valid_in(fv), .frame_rd_in(frd), .pma_data_out(pd),
      .pma_ctrl_out(pc), .pma_valid_out(pv), .txq_full_flag_out(ff),
      .txq_partial_full_flag_out(pff), .txq_empty_flag_out(ef),
      .txq_partial_empty_flag_out(pef), .txq_word_deleted_pulse_out(dp),
      .txq_word_inserted_pulse_out(ip), .irq_out(irq),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic test_done;
      if (failures == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic cmp(input string n, input logic [63:0] x, input logic [63:0] s);
      checks++;
      if (s !== x) begin
         failures++;
         $display("Error %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge clk);
         if (awready && awvalid) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready && wvalid) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      cmp("bresp", r, bresp);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r, input logic [31:0] m = 32'hffff_ffff);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      cmp("rdata", d, rdata & m);
      cmp("rresp", r, rresp);
      rready <= 1'b0;
   endtask

   always @(posedge clk) begin
      cyc++;
      dels += dp;
      ins += ip;
      if (regm) cmp("reg_valid", fvp, pv);
      fvp = fv;
      if (pv && gap) begin
         if (last > 0) cmp("read_gap", 4, cyc - last);
         last = cyc;
      end
      if (pv && !ign) begin
         if (q.size() == 0) cmp("pma_valid", 0, pv);
         else begin
            e = q.pop_front();
            cmp("pma_data", e.data ^ {64{inv}}, pd);
            cmp("pma_ctrl", e.ctrl & 9'h007, pc);
         end
      end
      if (!rst && fv && (regm || q.size() < 32)) q.push_back(fw);
      if (cyc == 5000) begin
         failures++;
         test_done();
      end
   end

   initial begin
      {rst, run, stop, frd, inv, ign, gap, regm, fvp} = 9'h100;
      {awaddr, araddr, wdata} = 48'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
      rd(OFS_THR, 32'h0004_171f, RESP_OKAY);
      rd(OFS_STAT, 32'h0000_0c00, RESP_OKAY);
      rd(8'h18, 32'h0, RESP_SLVERR);
      wr(8'h18, 32'hffff_ffff, RESP_SLVERR);
      wr(OFS_STAT, 32'h0000_00ff, RESP_OKAY);
      rd(OFS_STAT, 32'h0000_0c00, RESP_OKAY);
      // Fill in elastic mode; the writer stops on the full flag.
      wr(OFS_CTRL, 32'h0000_0008, RESP_OKAY);
      wr(OFS_ISTAT, 32'h0000_0003, RESP_OKAY);
      wr(OFS_IMASK, 32'h0000_0001, RESP_OKAY);
      cmp("irq", 0, irq);
      stop <= 1'b1;
      run <= 1'b1;
      repeat (40) @(posedge clk);
      run <= 1'b0;
      rd(OFS_STAT, 32'h0000_031f, RESP_OKAY);
      stop <= 1'b0;
      run <= 1'b1;
      repeat (3) @(posedge clk);
      run <= 1'b0;
      repeat (3) @(posedge clk);
      cmp("deleted", 2, dels);
      cmp("inserted", 0, ins);
      rd(OFS_STAT, 32'h0000_0320, RESP_OKAY);
      rd(OFS_ISTAT, 32'h0000_0001, RESP_OKAY);
      repeat (2) @(posedge clk);
      cmp("irq", 1, irq);
      wr(OFS_IMASK, 32'h0, RESP_OKAY);
      repeat (2) @(posedge clk);
      cmp("irq", 0, irq);
      wr(OFS_IMASK, 32'h0000_0001, RESP_OKAY);
      wr(OFS_ISTAT, 32'h0000_0001, RESP_OKAY);
      repeat (2) @(posedge clk);
      cmp("irq", 0, irq);
      // Drain by frame requests with outgoing data inverted.
      wr(OFS_CTRL, 32'h0000_0004, RESP_OKAY);
      inv = 1'b1;
      frd <= 1'b1;
      repeat (28) @(posedge clk);
      frd <= 1'b0;
      repeat (3) @(posedge clk);
      rd(OFS_STAT, 32'h0000_0804, RESP_OKAY);
      frd <= 1'b1;
      repeat (10) @(posedge clk);
      frd <= 1'b0;
      rd(OFS_STAT, 32'h0000_0c00, RESP_OKAY);
      cmp("queue", 0, q.size());
      // Phase mode reads every fourth cycle on its own.
      inv = 1'b0;
      wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
      wr(OFS_DIV, 32'h0000_0003, RESP_OKAY);
      gap = 1'b1;
      run <= 1'b1;
      repeat (6) @(posedge clk);
      run <= 1'b0;
      repeat (40) @(posedge clk);
      gap = 1'b0;
      cmp("queue", 0, q.size());
      // Reading while empty in 10GBASE-R mode inserts words.
      wr(OFS_DIV, 32'h0, RESP_OKAY);
      ign = 1'b1;
      wr(OFS_CTRL, 32'h0000_0009, RESP_OKAY);
      repeat (5) @(posedge clk);
      cmp("inserted", 1, ins > 0);
      rd(OFS_ISTAT, 32'h0000_0002, RESP_OKAY, 32'h0000_0002);
      // Register mode passes each word through one stage.
      wr(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
      repeat (2) @(posedge clk);
      ign = 1'b0;
      regm = 1'b1;
      run <= 1'b1;
      repeat (5) @(posedge clk);
      run <= 1'b0;
      repeat (3) @(posedge clk);
      cmp("queue", 0, q.size());
      test_done();
   end
endmodule // test_ten_g_pcs_tx_fifo
